//--- hdl/mfp_pkg.sv
package mfp_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    // Open-detect mask interval in ns and its cycle count at 100 MHz
    localparam int CLK_PERIOD_NS = 10;
    localparam int OPEN_MASK_NS = 2000;
    localparam int OPEN_MASK_CYC = OPEN_MASK_NS / CLK_PERIOD_NS;
    localparam int MASK_W = 16;
    localparam logic [MASK_W-1:0] OPEN_MASK_LIM = MASK_W'(OPEN_MASK_CYC);
    localparam logic [1:0] OPEN_COUNT_NEED = 2'h3;
    localparam logic [1:0] OPEN_COUNT_RST = 2'h0;

    typedef struct packed {
        logic short_trip;
        logic open_seen;
        logic over_temp;
    } mfp_sense_t;

    typedef struct packed {
        logic short_latched;
        logic open_latched;
        logic temp_active;
    } mfp_status_t;
endpackage : mfp_pkg

//--- hdl/mfp_fault_protect.sv
// How it works
// - Sense voltage above short trip threshold disables all outputs at once.
// - Short fault latches outputs off until power-on reset; nothing else clears.
// - Positive sense voltage during PWM off-time flags a possible open coil.
// - Open protection needs three consecutive flagged off-times; normal cycle restarts.
// - Shutdown only when accumulated breakdown time exceeds the mask interval.
// - Without genuine breakdown meeting criteria, outputs keep driving normally.
// - Die temperature above thermal shutdown threshold disables every output.
// - Power-on reset returns sequencer home, so outputs restart from home.
`timescale 1ns/1ps
`default_nettype none
module mfp_fault_protect (
    input wire logic ref_clk,
    input wire logic rst,
    input wire mfp_pkg::mfp_sense_t sense_in,
    input wire logic pwm_off,
    input wire logic pwm_cycle_end,
    output logic out_enable,
    output logic seq_home,
    output mfp_pkg::mfp_status_t status
);
    import mfp_pkg::*;

    logic short_r;
    logic open_r;
    logic temp_r;
    logic [1:0] open_cnt_r;
    logic [1:0] open_cnt_nxt;
    logic [MASK_W-1:0] brk_time_r;
    logic cyc_flag_r;
    logic home_r;
    logic en_r;

    // ------------------------------------------------------------
    // Short circuit
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            short_r <= 1'b0;
        end else if (sense_in.short_trip) begin
            short_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Open coil
    // ------------------------------------------------------------
    // Flag remembers if this PWM cycle's off-time saw positive sense voltage
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cyc_flag_r <= 1'b0;
        end else if (pwm_cycle_end) begin
            cyc_flag_r <= 1'b0;
        end else if (pwm_off && sense_in.open_seen) begin
            cyc_flag_r <= 1'b1;
        end
    end

    always_comb begin
        open_cnt_nxt = open_cnt_r;
        if (pwm_cycle_end) begin
            if (cyc_flag_r || (pwm_off && sense_in.open_seen)) begin
                if (open_cnt_r != OPEN_COUNT_NEED) begin
                    open_cnt_nxt = open_cnt_r + 2'h1;
                end
            end else begin
                open_cnt_nxt = OPEN_COUNT_RST;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            open_cnt_r <= OPEN_COUNT_RST;
        end else begin
            open_cnt_r <= open_cnt_nxt;
        end
    end

    // Breakdown time accumulates across flagged cycles; a clean cycle discards it
    // so isolated surge pulses never add up to a trip.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            brk_time_r <= '0;
        end else if (open_cnt_nxt == OPEN_COUNT_RST && pwm_cycle_end) begin
            brk_time_r <= '0;
        end else if (pwm_off && sense_in.open_seen && brk_time_r != '1) begin
            brk_time_r <= brk_time_r + MASK_W'(1);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            open_r <= 1'b0;
        end else if (open_cnt_r == OPEN_COUNT_NEED && brk_time_r > OPEN_MASK_LIM) begin
            open_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Thermal
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            temp_r <= 1'b0;
        end else begin
            temp_r <= sense_in.over_temp;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Short trip feeds the enable register straight from the input, so the enable falls on the next edge without waiting for the latch
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            en_r <= 1'b0;
        end else begin
            en_r <= !(short_r || sense_in.short_trip || open_r || temp_r
                      || sense_in.over_temp);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            home_r <= 1'b1;
        end else begin
            home_r <= 1'b0;
        end
    end

    assign out_enable = en_r;
    assign seq_home = home_r;
    assign status = '{short_latched: short_r, open_latched: open_r, temp_active: temp_r};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence short_hit_s;
        sense_in.short_trip;
    endsequence

    short_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        short_hit_s |=> !out_enable) else $error("short did not disable outputs");
    short_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        short_r |=> short_r && !out_enable) else $error("short fault cleared");
    temp_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        sense_in.over_temp |=> !out_enable) else $error("thermal did not disable");
    open_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        open_r |=> open_r && !out_enable) else $error("open fault cleared");
    open_need_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(open_r) |-> $past(open_cnt_r) == OPEN_COUNT_NEED)
        else $error("open trip before three cycles");
    open_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(open_r) |-> $past(brk_time_r) > OPEN_MASK_LIM)
        else $error("open trip inside mask time");
    count_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        pwm_cycle_end && !cyc_flag_r && !(pwm_off && sense_in.open_seen)
        |=> open_cnt_r == OPEN_COUNT_RST) else $error("clean cycle kept count");
    normal_run_a: assert property (@(posedge ref_clk) disable iff (rst)
        !short_r && !open_r && !temp_r && !sense_in.short_trip && !sense_in.over_temp
        |=> out_enable) else $error("outputs off without fault");
    home_release_a: assert property (@(posedge ref_clk) disable iff (rst)
        seq_home |=> !seq_home) else $error("home held after reset");

    // ------------------------------------------------------------
    // Open coil checks
    // ------------------------------------------------------------
    // Breakdown inside the off-time, away from the cycle end that clears the flag
    sequence mid_brk_s;
        pwm_off && sense_in.open_seen && !pwm_cycle_end;
    endsequence

    // Cycle end with no breakdown anywhere in the cycle, end cycle included
    sequence clean_end_s;
        pwm_cycle_end && !cyc_flag_r && !(pwm_off && sense_in.open_seen);
    endsequence

    sequence flagged_end_s;
        pwm_cycle_end && cyc_flag_r && open_cnt_r != OPEN_COUNT_NEED;
    endsequence

    // Both the cycle count and the mask time are met
    sequence open_ready_s;
        open_cnt_r == OPEN_COUNT_NEED && brk_time_r > OPEN_MASK_LIM;
    endsequence

    // Latch first, then the registered enable falls one edge later
    sequence open_trip_s;
        open_r ##1 !out_enable;
    endsequence

    flag_set_a: assert property (@(posedge ref_clk) disable iff (rst)
        mid_brk_s |=> cyc_flag_r) else $error("off-time breakdown not flagged");
    flag_ignore_a: assert property (@(posedge ref_clk) disable iff (rst)
        !pwm_off && !cyc_flag_r |=> !cyc_flag_r) else $error("on-time sense flagged");

    count_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        !pwm_cycle_end |=> $stable(open_cnt_r)) else $error("count moved inside a cycle");
    count_step_a: assert property (@(posedge ref_clk) disable iff (rst)
        flagged_end_s |=> open_cnt_r == 2'($past(open_cnt_r) + 2'h1))
        else $error("flagged cycle not counted");
    brk_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        clean_end_s |=> brk_time_r == '0) else $error("clean cycle kept breakdown time");
    brk_sat_a: assert property (@(posedge ref_clk) disable iff (rst)
        brk_time_r == '1 && !pwm_cycle_end |=> brk_time_r == '1) else $error("breakdown wrapped");
    open_trip_a: assert property (@(posedge ref_clk) disable iff (rst)
        open_ready_s |=> open_trip_s) else $error("open fault did not shut outputs");

    open_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
        open_ready_s |=> status.open_latched) else $error("open fault not reported");

    // ------------------------------------------------------------
    // Fault flag checks
    // ------------------------------------------------------------
    short_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
        short_hit_s |=> status.short_latched) else $error("short not latched");
    temp_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
        sense_in.over_temp |=> status.temp_active) else $error("thermal not flagged");
    temp_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        !sense_in.over_temp |=> !status.temp_active) else $error("thermal flag stuck");
endmodule : mfp_fault_protect
`default_nettype wire

//--- dv/mfp_chopper_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Fixed off-time PWM chopper
// ------------------------------------------------------------
module mfp_chopper_model #(
    parameter int PER = 100,
    parameter int ON = 20
) (
    input wire logic ref_clk,
    input wire logic rst,
    output logic [6:0] phase,
    output logic pwm_off,
    output logic pwm_cycle_end
);
    initial phase = 7'h00;
    // Sampled at the edge, updated just after it, so a reset released by the
    // bench a moment after the edge cannot race the step
    always @(posedge ref_clk) begin
        phase <= #1 ((rst || phase == 7'(PER - 1)) ? 7'h00 : phase + 7'h01);
    end
    assign pwm_off = phase >= 7'(ON);
    assign pwm_cycle_end = phase == 7'(PER - 1);
endmodule : mfp_chopper_model
`default_nettype wire

//--- dv/mfp_fault_protect_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Bench
// ------------------------------------------------------------
module mfp_fault_protect_tb;
    import mfp_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic trip = 1'b0;
    logic hot = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [6:0] phase;
    logic pwm_off;
    logic pwm_cycle_end;
    logic out_enable;
    logic seq_home;
    mfp_status_t status;
    mfp_sense_t sense_in;
    int fail_count = 0;
    int tests_run = 0;
    logic coil_pos;
    // Modes: clean, whole off-time, short noise after turn-off, on-time only
    assign coil_pos = (mode == 2'h1) ? pwm_off :
        (mode == 2'h2) ? (pwm_off && phase < 7'h19) :
        (mode == 2'h3) && phase > 7'h04 && phase < 7'h0f;
    // One driver for the whole carrier
    assign sense_in = '{short_trip: trip, open_seen: coil_pos, over_temp: hot};
    mfp_chopper_model u_mfp_chopper_model (.ref_clk(ref_clk), .rst(rst), .phase(phase),
        .pwm_off(pwm_off), .pwm_cycle_end(pwm_cycle_end));
    mfp_fault_protect u_mfp_fault_protect (.ref_clk(ref_clk), .rst(rst), .sense_in(sense_in),
        .pwm_off(pwm_off), .pwm_cycle_end(pwm_cycle_end), .out_enable(out_enable),
        .seq_home(seq_home), .status(status));
    initial forever #5 ref_clk = ~ref_clk;
    task automatic give_verdict();
        if (fail_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask : chk
    task automatic ticks(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : ticks
    task automatic do_reset();
        rst = 1'b1;
        ticks(12);
        chk("seq_home in reset", 1'b1, seq_home);
        chk("out_enable in reset", 1'b0, out_enable);
        rst = 1'b0;
        ticks(2);
        chk("out_enable after reset", 1'b1, out_enable);
        chk("seq_home after reset", 1'b0, seq_home);
    endtask : do_reset
    // The opening sync always leaves one clean PWM cycle before the flagged ones
    task automatic run_mode(input logic [1:0] m, input int n);
        @(posedge ref_clk iff pwm_cycle_end);
        #1;
        mode = m;
        repeat (n) @(posedge ref_clk iff pwm_cycle_end);
        #1;
        mode = 2'h0;
        ticks(3);
    endtask : run_mode
    task automatic t_thermal();
        hot = 1'b1;
        ticks(3);
        chk("out_enable hot", 1'b0, out_enable);
        chk("temp_active", 1'b1, status.temp_active);
        hot = 1'b0;
        ticks(3);
        chk("out_enable cooled", 1'b1, out_enable);
    endtask : t_thermal
    task automatic t_ignored();
        run_mode(2'h2, 4);
        chk("out_enable noise", 1'b1, out_enable);
        do_reset();
        run_mode(2'h3, 4);
        chk("out_enable on-time", 1'b1, out_enable);
        run_mode(2'h1, 2);
        run_mode(2'h1, 2);
        chk("open_latched broken run", 1'b0, status.open_latched);
    endtask : t_ignored
    task automatic t_open();
        run_mode(2'h1, 3);
        chk("open_latched", 1'b1, status.open_latched);
        chk("out_enable open", 1'b0, out_enable);
        run_mode(2'h0, 2);
        chk("out_enable open held", 1'b0, out_enable);
    endtask : t_open
    task automatic t_short();
        trip = 1'b1;
        ticks(1);
        chk("out_enable short", 1'b0, out_enable);
        trip = 1'b0;
        ticks(50);
        chk("out_enable short held", 1'b0, out_enable);
        chk("short_latched", 1'b1, status.short_latched);
    endtask : t_short
    initial begin
        do_reset();
        t_thermal();
        t_ignored();
        do_reset();
        t_open();
        do_reset();
        t_short();
        do_reset();
        give_verdict();
    end
    // Run needs about 2500 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        give_verdict();
    end
endmodule : mfp_fault_protect_tb
`default_nettype wire
